// file: include/dscrb_consts.vh
`ifndef DSCRB_CONSTS_VH
`define DSCRB_CONSTS_VH
// register offsets
`define DSCRB_OFF_CFG1        8'h00
`define DSCRB_OFF_ADDR        8'h01
`define DSCRB_OFF_OUTF        8'h02
`define DSCRB_OFF_EQSS        8'h03
// reset values
`define DSCRB_RST_CFG1        8'h00
`define DSCRB_RST_ADDR        8'h70
`define DSCRB_RST_OUTF        8'h00
`define DSCRB_RST_EQSS        8'h00
// config one fields
`define DSCRB_LOW_FREQ_RANGE_SELECT_BIT      7
`define DSCRB_MAP_BIT         6
`define DSCRB_FILT_HI         3
`define DSCRB_FILT_LO         2
`define DSCRB_SLEEP_BIT       1
`define DSCRB_REGCFG_BIT      0
`define DSCRB_REGCFG_ENABLE   8'h01
// address register fields
`define DSCRB_ADDRSRC_BIT     7
// output features fields
`define DSCRB_OEN_BIT         7
`define DSCRB_OSS_BIT         6
`define DSCRB_SWING_BIT       3
`define DSCRB_OSC_HI          2
`define DSCRB_OSC_LO          0
// equalizer / spread fields
`define DSCRB_EQG_HI          7
`define DSCRB_EQG_LO          5
`define DSCRB_EQEN_BIT        4
`define DSCRB_SSC_HI          2
`define DSCRB_SSC_LO          0
// strap addresses
`define DSCRB_STRAP_ADDR0     7'h71
`define DSCRB_STRAP_ADDR1     7'h72
`define DSCRB_STRAP_ADDR2     7'h73
`define DSCRB_STRAP_ADDR3     7'h76
// spread divisors
`define DSCRB_DIV_HI_A        16'd2168
`define DSCRB_DIV_HI_B        16'd1300
`define DSCRB_DIV_LO_A        16'd625
`define DSCRB_DIV_LO_B        16'd385
`endif

// file: rtl/dscrb_regfile.v
`timescale 1ns/1ps
`include "dscrb_consts.vh"
module dscrb_regfile (
  // clock and reset
  input  wire       clk,
  input  wire       resetn,
  // write port
  input  wire       wr_en,
  input  wire [7:0] wr_addr,
  input  wire [7:0] wr_data,
  // read port
  input  wire [7:0] rd_addr,
  output reg  [7:0] rd_data,
  // contents
  output wire [31:0] regs_flat
);
  wire [7:0] rst_val [0:3];
  assign rst_val[0] = `DSCRB_RST_CFG1;
  assign rst_val[1] = `DSCRB_RST_ADDR;
  assign rst_val[2] = `DSCRB_RST_OUTF;
  assign rst_val[3] = `DSCRB_RST_EQSS;
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_reg
      reg [7:0] data_q;
      always @(posedge clk) begin
        if (!resetn) begin
          data_q <= rst_val[i];
        end else if (wr_en && wr_addr == i) begin
          data_q <= wr_data;
        end
      end
      assign regs_flat[8*i+7:8*i] = data_q;
    end
  endgenerate
  always @(posedge clk) begin
    if (!resetn) begin
      rd_data <= 8'h00;
    end else if (rd_addr[7:2] == 6'h00) begin
      rd_data <= regs_flat[8*rd_addr[1:0] +: 8];
    end else begin
      rd_data <= 8'h00;
    end
  end
endmodule // dscrb_regfile

// file: rtl/dscrb_top.v
// Operation
// - config bit 7 picks the spread clock range, 0 for 20-65 MHz, 1 for 10-20 MHz.
// - config bit 6 picks whether lsb or msb bits go to output channel three.
// - config bits 3:2 disable (00) or enable (01) the control filter; 10/11 reserved.
// - config bit 1 puts the device to sleep keeping registers, separate from power down.
// - config bit 0 selects pin or register configuration, bus address excluded.
// - address bit 7 picks strap pin address or register address.
// - address bits 6:0 hold the bus address; only four values are valid.
// - features bit 7 is output enable and bit 6 output sleep state, both reset to 0.
// - features bit 3 selects low (250 mV) or high (400 mV) output swing.
// - features bits 2:0 select oscillator frequency, 000 off, 001 reserved.
// - bit 4 of the third features register enables equalizer, gain from bits 7:5.
// - with low range clear, spread codes use clk/2168 (1-4) or clk/1300 (5-7).
// - with low range set, spread codes use clk/625 (1-4) or clk/385 (5-7).
// - registers are reached over a two-wire bus, answering at own address.
// - register fields other than the bus address override straps whenever bit 0 of register 0 is set.
`timescale 1ns/1ps
`include "dscrb_consts.vh"
module dscrb_top (
  // clock and reset
  input  wire       CLK,
  input  wire       RESETN,
  // serial control bus
  input  wire       SCL,
  input  wire       SDA_IN,
  output reg        SDA_OUT,
  output reg        SDA_OE_N,
  // strap pins
  input  wire [1:0] ADDRESS_STRAP_PIN,
  input  wire       STRAP_BIT_ORDER_MAP_SELECT,
  input  wire       STRAP_OUTPUT_SWING_SELECT,
  input  wire       STRAP_OUTPUT_ENABLE,
  input  wire       STRAP_OUTPUT_SLEEP_STATE,
  // effective configuration
  output reg        LOW_FREQ_RANGE_SELECT,
  output reg        BIT_ORDER_MAP_SELECT,
  output reg        CONTROL_FILTER_ENABLE,
  output reg        SLEEP_MODE,
  output reg        OUTPUT_ENABLE_BIT,
  output reg        OUTPUT_SLEEP_STATE_SELECT,
  output reg        OUTPUT_SWING_SELECT,
  output reg  [2:0] OSCILLATOR_FREQUENCY_SELECT,
  output reg        EQUALIZER_ENABLE_BIT,
  output reg  [2:0] EQUALIZER_GAIN_FIELD,
  output reg        SPREAD_CLOCK_ENABLE,
  output reg  [2:0] SPREAD_CLOCK_SETTING,
  output reg  [15:0] SPREAD_MOD_DIVISOR,
  output reg  [6:0] BUS_ADDRESS
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_AACK = 3'd2;
  localparam ST_WDAT = 3'd3;
  localparam ST_WACK = 3'd4;
  localparam ST_RDAT = 3'd5;
  localparam ST_RACK = 3'd6;
  // input synchronisers
  reg  [1:0] scl_s_q;
  reg  [1:0] sda_s_q;
  reg  [1:0] strap_a_q;
  reg  [1:0] strap_b_q;
  reg  [3:0] strap_c_q;
  reg  [3:0] strap_d_q;
  reg        scl_d1_q;
  reg        sda_d1_q;
  always @(posedge CLK) begin
    if (!RESETN) begin
      scl_s_q   <= 2'h3;
      sda_s_q   <= 2'h3;
      scl_d1_q  <= 1'b1;
      sda_d1_q  <= 1'b1;
      strap_a_q <= 2'h0;
      strap_b_q <= 2'h0;
      strap_c_q <= 4'h0;
      strap_d_q <= 4'h0;
    end else begin
      scl_s_q   <= {scl_s_q[0], SCL};
      sda_s_q   <= {sda_s_q[0], SDA_IN};
      scl_d1_q  <= scl_s_q[1];
      sda_d1_q  <= sda_s_q[1];
      strap_a_q <= ADDRESS_STRAP_PIN;
      strap_b_q <= strap_a_q;
      strap_c_q <= {STRAP_BIT_ORDER_MAP_SELECT, STRAP_OUTPUT_SWING_SELECT,
                    STRAP_OUTPUT_ENABLE, STRAP_OUTPUT_SLEEP_STATE};
      strap_d_q <= strap_c_q;
    end
  end
  wire scl_v   = scl_s_q[1];
  wire sda_v   = sda_s_q[1];
  wire scl_ris = scl_v & ~scl_d1_q;
  wire scl_fal = ~scl_v & scl_d1_q;
  wire start_c = scl_v & scl_d1_q & ~sda_v & sda_d1_q;
  wire stop_c  = scl_v & scl_d1_q & sda_v & ~sda_d1_q;
  // register file
  wire [31:0] regs;
  wire [7:0]  cfg1 = regs[7:0];
  wire [7:0]  addr_r = regs[15:8];
  wire [7:0]  outf = regs[23:16];
  wire [7:0]  eqss = regs[31:24];
  reg         wr_en_q;
  reg  [7:0]  ptr_q;
  reg  [7:0]  shift_q;
  wire [7:0]  rd_data;
  dscrb_regfile i_dscrb_regfile (
    .clk       (CLK),
    .resetn    (RESETN),
    .wr_en     (wr_en_q),
    .wr_addr   (ptr_q),
    .wr_data   (shift_q),
    .rd_addr   (ptr_q),
    .rd_data   (rd_data),
    .regs_flat (regs)
  );
  // own address
  reg [6:0] strap_addr;
  always @* begin
    case (strap_b_q)
      2'h0:    strap_addr = `DSCRB_STRAP_ADDR0;
      2'h1:    strap_addr = `DSCRB_STRAP_ADDR1;
      2'h2:    strap_addr = `DSCRB_STRAP_ADDR2;
      default: strap_addr = `DSCRB_STRAP_ADDR3;
    endcase
  end
  wire [6:0] own_addr = addr_r[`DSCRB_ADDRSRC_BIT] ? addr_r[6:0] : strap_addr;
  // two-wire slave
  reg [2:0] st_q;
  reg [2:0] bit_q;
  reg       rw_q;
  reg       ptr_set_q;
  reg       got_q;
  always @(posedge CLK) begin
    if (!RESETN) begin
      st_q      <= ST_IDLE;
      bit_q     <= 3'h0;
      rw_q      <= 1'b0;
      ptr_set_q <= 1'b0;
      got_q     <= 1'b0;
      ptr_q     <= 8'h00;
      shift_q   <= 8'h00;
      wr_en_q   <= 1'b0;
      SDA_OUT   <= 1'b1;
      SDA_OE_N  <= 1'b1;
    end else begin
      wr_en_q <= 1'b0;
      if (stop_c) begin
        st_q     <= ST_IDLE;
        SDA_OE_N <= 1'b1;
      end else if (start_c) begin
        st_q     <= ST_ADDR;
        bit_q    <= 3'h0;
        got_q    <= 1'b0;
        SDA_OE_N <= 1'b1;
      end else begin
        case (st_q)
          ST_IDLE: begin
            SDA_OE_N <= 1'b1;
          end
          ST_ADDR: begin
            if (scl_ris) begin
              shift_q <= {shift_q[6:0], sda_v};
              bit_q   <= bit_q + 3'h1;
              got_q   <= bit_q == 3'h7;
            end else if (scl_fal && got_q) begin
              if (shift_q[7:1] == own_addr) begin
                rw_q     <= shift_q[0];
                ptr_set_q <= 1'b0;
                SDA_OUT  <= 1'b0;
                SDA_OE_N <= 1'b0;
                st_q     <= ST_AACK;
              end else begin
                st_q <= ST_IDLE;
              end
            end
          end
          ST_AACK, ST_WACK: begin
            if (scl_fal) begin
              bit_q <= 3'h0;
              if (rw_q) begin
                shift_q  <= rd_data;
                SDA_OUT  <= rd_data[7];
                SDA_OE_N <= rd_data[7];
                st_q     <= ST_RDAT;
              end else begin
                SDA_OE_N <= 1'b1;
                st_q     <= ST_WDAT;
              end
            end
          end
          ST_WDAT: begin
            if (scl_ris) begin
              shift_q <= {shift_q[6:0], sda_v};
              bit_q   <= bit_q + 3'h1;
            end else if (scl_fal && bit_q == 3'h0) begin
              if (!ptr_set_q) begin
                ptr_q     <= shift_q;
                ptr_set_q <= 1'b1;
              end else begin
                wr_en_q <= 1'b1;
              end
              SDA_OUT  <= 1'b0;
              SDA_OE_N <= 1'b0;
              st_q     <= ST_WACK;
            end
          end
          ST_RDAT: begin
            if (scl_fal) begin
              bit_q <= bit_q + 3'h1;
              if (bit_q == 3'h7) begin
                SDA_OE_N <= 1'b1;
                ptr_q    <= ptr_q + 8'h01;
                st_q     <= ST_RACK;
              end else begin
                shift_q  <= {shift_q[6:0], 1'b0};
                SDA_OUT  <= shift_q[6];
                SDA_OE_N <= shift_q[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_ris) begin
              st_q <= sda_v ? ST_IDLE : ST_AACK;
            end
          end
          default: st_q <= ST_IDLE;
        endcase
        if (wr_en_q) begin
          ptr_q <= ptr_q + 8'h01;
        end
      end
    end
  end
  // effective configuration
  wire reg_mode = (cfg1 == `DSCRB_REGCFG_ENABLE) | cfg1[`DSCRB_REGCFG_BIT];
  reg [15:0] div_d;
  always @* begin
    if (eqss[`DSCRB_SSC_HI:`DSCRB_SSC_LO] == 3'h0) begin
      div_d = 16'h0000;
    end else if (cfg1[`DSCRB_LOW_FREQ_RANGE_SELECT_BIT]) begin
      div_d = eqss[2] & (eqss[1:0] != 2'h0) ? `DSCRB_DIV_LO_B : `DSCRB_DIV_LO_A;
    end else begin
      div_d = eqss[2] & (eqss[1:0] != 2'h0) ? `DSCRB_DIV_HI_B : `DSCRB_DIV_HI_A;
    end
  end
  always @(posedge CLK) begin
    if (!RESETN) begin
      LOW_FREQ_RANGE_SELECT       <= 1'b0;
      BIT_ORDER_MAP_SELECT        <= 1'b0;
      CONTROL_FILTER_ENABLE       <= 1'b0;
      SLEEP_MODE                  <= 1'b0;
      OUTPUT_ENABLE_BIT           <= 1'b0;
      OUTPUT_SLEEP_STATE_SELECT   <= 1'b0;
      OUTPUT_SWING_SELECT         <= 1'b0;
      OSCILLATOR_FREQUENCY_SELECT <= 3'h0;
      EQUALIZER_ENABLE_BIT        <= 1'b0;
      EQUALIZER_GAIN_FIELD        <= 3'h0;
      SPREAD_CLOCK_ENABLE         <= 1'b0;
      SPREAD_CLOCK_SETTING        <= 3'h0;
      SPREAD_MOD_DIVISOR          <= 16'h0000;
      BUS_ADDRESS                 <= `DSCRB_STRAP_ADDR0;
    end else begin
      BUS_ADDRESS <= own_addr;
      SLEEP_MODE  <= cfg1[`DSCRB_SLEEP_BIT];
      if (reg_mode) begin
        LOW_FREQ_RANGE_SELECT       <= cfg1[`DSCRB_LOW_FREQ_RANGE_SELECT_BIT];
        BIT_ORDER_MAP_SELECT        <= cfg1[`DSCRB_MAP_BIT];
        CONTROL_FILTER_ENABLE       <= cfg1[`DSCRB_FILT_HI:`DSCRB_FILT_LO] == 2'h1;
        OUTPUT_ENABLE_BIT           <= outf[`DSCRB_OEN_BIT];
        OUTPUT_SLEEP_STATE_SELECT   <= outf[`DSCRB_OSS_BIT];
        OUTPUT_SWING_SELECT         <= outf[`DSCRB_SWING_BIT];
        OSCILLATOR_FREQUENCY_SELECT <= outf[`DSCRB_OSC_HI:`DSCRB_OSC_LO];
        EQUALIZER_ENABLE_BIT        <= eqss[`DSCRB_EQEN_BIT];
        EQUALIZER_GAIN_FIELD        <= eqss[`DSCRB_EQG_HI:`DSCRB_EQG_LO];
        SPREAD_CLOCK_ENABLE         <= div_d != 16'h0000;
        SPREAD_CLOCK_SETTING        <= eqss[`DSCRB_SSC_HI:`DSCRB_SSC_LO];
        SPREAD_MOD_DIVISOR          <= div_d;
      end else begin
        LOW_FREQ_RANGE_SELECT       <= 1'b0;
        BIT_ORDER_MAP_SELECT        <= strap_d_q[3];
        CONTROL_FILTER_ENABLE       <= 1'b0;
        OUTPUT_ENABLE_BIT           <= strap_d_q[1];
        OUTPUT_SLEEP_STATE_SELECT   <= strap_d_q[0];
        OUTPUT_SWING_SELECT         <= strap_d_q[2];
        OSCILLATOR_FREQUENCY_SELECT <= 3'h0;
        EQUALIZER_ENABLE_BIT        <= 1'b0;
        EQUALIZER_GAIN_FIELD        <= 3'h0;
        SPREAD_CLOCK_ENABLE         <= 1'b0;
        SPREAD_CLOCK_SETTING        <= 3'h0;
        SPREAD_MOD_DIVISOR          <= 16'h0000;
      end
    end
  end
endmodule // dscrb_top

// file: verification/dscrb_properties.sv
`timescale 1ns/1ps
module dscrb_props (
  // watched ports
  input wire        CLK,
  input wire        RESETN,
  input wire        SDA_OE_N,
  input wire        LOW_FREQ_RANGE_SELECT,
  input wire        SPREAD_CLOCK_ENABLE,
  input wire [2:0]  SPREAD_CLOCK_SETTING,
  input wire [15:0] SPREAD_MOD_DIVISOR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  wire lo = LOW_FREQ_RANGE_SELECT;
  wire [2:0] s = SPREAD_CLOCK_SETTING;
  spread_enable_a: assert property (SPREAD_CLOCK_ENABLE == (s != 3'h0))
    else $error("spread enable disagrees with setting");
  spread_off_a: assert property (s == 3'h0 |-> SPREAD_MOD_DIVISOR == 16'h0000)
    else $error("divisor not zero with spreading off");
  high_short_a: assert property (!lo && s inside {[1:4]} |-> SPREAD_MOD_DIVISOR == 16'h0878)
    else $error("normal range divisor wrong for codes 1 to 4");
  high_long_a: assert property (!lo && s > 3'h4 |-> SPREAD_MOD_DIVISOR == 16'h0514)
    else $error("normal range divisor wrong for codes 5 to 7");
  low_short_a: assert property (lo && s inside {[1:4]} |-> SPREAD_MOD_DIVISOR == 16'h0271)
    else $error("low range divisor wrong for codes 1 to 4");
  low_long_a: assert property (lo && s > 3'h4 |-> SPREAD_MOD_DIVISOR == 16'h0181)
    else $error("low range divisor wrong for codes 5 to 7");
  ack_hold_a: assert property ($fell(SDA_OE_N) |-> !SDA_OE_N [*4])
    else $error("data line drive too short");
  drive_steady_a: assert property ($changed(SDA_OE_N) |=> $stable(SDA_OE_N) [*3])
    else $error("data line drive toggles too fast");
endmodule // dscrb_props
bind dscrb_top dscrb_props i_dscrb_props (.CLK(CLK), .RESETN(RESETN), .SDA_OE_N(SDA_OE_N),
  .LOW_FREQ_RANGE_SELECT(LOW_FREQ_RANGE_SELECT), .SPREAD_CLOCK_ENABLE(SPREAD_CLOCK_ENABLE),
  .SPREAD_CLOCK_SETTING(SPREAD_CLOCK_SETTING), .SPREAD_MOD_DIVISOR(SPREAD_MOD_DIVISOR));

// file: verification/dscrb_host.sv
`timescale 1ns/1ps
module dscrb_host (
  // clock
  input  wire clk,
  // bus wire level and host drive
  input  wire sda,
  output reg  scl,
  output reg  sda_o
);
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // start or repeated start
  task automatic start();
    sda_o = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_o = 1'b0;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_o = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_o = 1'b1;
    tick(4);
  endtask
  // nine bits msb first, the ninth is the acknowledge slot
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int k = 8; k >= 0; k--) begin
      sda_o = tx[k];
      tick(2);
      scl = 1'b1;
      tick(4);
      rx[k] = sda;
      scl = 1'b0;
      tick(2);
    end
  endtask
endmodule // dscrb_host

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
  // clock, reset and straps
  logic        CLK;
  logic        RESETN;
  logic [1:0]  strap;
  logic [3:0]  pins;
  // bus lines
  wire         scl, sda_o, sda_out, sda_oe_n, sda;
  // effective configuration
  wire         lfr, map, filt, slp, output_enable_bit, oss, swing, eqen, spen;
  wire  [2:0]  osc, gain, sset;
  wire  [15:0] div;
  wire  [6:0]  badr;
  int          n_fail, compares, cyc;
  logic        ak;
  logic [31:0] d;
  logic [7:0]  c, f, e;
  logic [15:0] x;
  assign sda = sda_o & (sda_oe_n | sda_out);
  dscrb_host i_dscrb_host (.clk(CLK), .sda(sda), .scl(scl), .sda_o(sda_o));
  dscrb_top i_dscrb_top (.CLK(CLK), .RESETN(RESETN), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .ADDRESS_STRAP_PIN(strap),
    .STRAP_BIT_ORDER_MAP_SELECT(pins[3]), .STRAP_OUTPUT_SWING_SELECT(pins[2]),
    .STRAP_OUTPUT_ENABLE(pins[1]), .STRAP_OUTPUT_SLEEP_STATE(pins[0]),
    .LOW_FREQ_RANGE_SELECT(lfr), .BIT_ORDER_MAP_SELECT(map), .CONTROL_FILTER_ENABLE(filt),
    .SLEEP_MODE(slp), .OUTPUT_ENABLE_BIT(output_enable_bit), .OUTPUT_SLEEP_STATE_SELECT(oss),
    .OUTPUT_SWING_SELECT(swing), .OSCILLATOR_FREQUENCY_SELECT(osc),
    .EQUALIZER_ENABLE_BIT(eqen), .EQUALIZER_GAIN_FIELD(gain), .SPREAD_CLOCK_ENABLE(spen),
    .SPREAD_CLOCK_SETTING(sset), .SPREAD_MOD_DIVISOR(div), .BUS_ADDRESS(badr));
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      print_verdict();
    end
  end
  // write n bytes from the low end of dt, starting at pointer p
  task automatic wr(input [6:0] a, input [7:0] p, input [31:0] dt, input int n, output ok);
    logic [8:0] r;
    i_dscrb_host.start();
    i_dscrb_host.xfer({a, 2'b01}, r);
    ok = ~r[0];
    i_dscrb_host.xfer({p, 1'b1}, r);
    for (int k = n - 1; k >= 0; k--) i_dscrb_host.xfer({dt[8*k+:8], 1'b1}, r);
    i_dscrb_host.stop();
  endtask
  // read four bytes from pointer p, last one not acknowledged
  task automatic rd(input [6:0] a, input [7:0] p, output [31:0] dt);
    logic [8:0] r;
    logic       ok;
    wr(a, p, 32'h0, 0, ok);
    i_dscrb_host.start();
    i_dscrb_host.xfer({a, 2'b11}, r);
    for (int k = 3; k >= 0; k--) begin
      i_dscrb_host.xfer({8'hff, k == 0}, r);
      dt[8*k+:8] = r[8:1];
    end
    i_dscrb_host.stop();
  endtask
  initial begin
    RESETN = 1'b0;
    strap = 2'h0;
    pins = 4'hf;
    repeat (8) @(negedge CLK);
    RESETN = 1'b1;
    repeat (6) @(negedge CLK);
    chk("badr", badr, 32'h71);
    chk("pins", {map, swing, output_enable_bit, oss, lfr, slp, spen}, 32'h78);
    rd(7'h71, 8'h00, d);
    chk("reset", d, 32'h00700000);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      c = {i[3], i[0], i[1:0], 1'b0, i[1], i[2], 1'b1};
      f = {i[1], i[0], i[3:2], i[3], i[2:0]};
      e = {i[2:0], i[3], i[0], i[2:0]};
      x = (i[2:0] == 0) ? 16'h0 : i[3] ? (i[2:0] < 5 ? 16'h0271 : 16'h0181)
                                       : (i[2:0] < 5 ? 16'h0878 : 16'h0514);
      wr(7'h71, 8'h00, {c, 8'h70, f, e}, 4, ak);
      chk("ack", ak, 1);
      chk("cfg", {lfr, map, filt, slp}, {i[3], i[0], i[1], i[2]});
      chk("feat", {output_enable_bit, oss, swing, osc}, {i[1], i[0], i[3], i[2:0]});
      chk("eq", {eqen, gain, spen, sset}, {i[3], i[2:0], |i[2:0], i[2:0]});
      chk("div", div, x);
      rd(7'h71, 8'h00, d);
      chk("rdback", d, {c, 8'h70, f, e});
    end
    $display("test table done");
    wr(7'h71, 8'h00, 32'h02, 1, ak);
    repeat (4) @(negedge CLK);
    chk("pinmode", {map, swing, output_enable_bit, oss, lfr, slp, spen}, 32'h7a);
    strap = 2'h3;
    pins = 4'h5;
    repeat (6) @(negedge CLK);
    chk("strap", badr, 32'h76);
    chk("pins2", {map, swing, output_enable_bit, oss}, 32'h5);
    wr(7'h71, 8'h01, 32'h0, 0, ak);
    chk("nack", ak, 0);
    wr(7'h76, 8'h01, 32'hf3, 1, ak);
    chk("regaddr", badr, 32'h73);
    rd(7'h73, 8'h01, d);
    chk("addrback", d, {8'hf3, f, e, 8'h00});
    wr(7'h73, 8'h01, 32'h70, 1, ak);
    chk("pinaddr", badr, 32'h76);
    $display("test address done");
    print_verdict();
  end
endmodule // tb
